// ### pimc_top.sv
// Port I/O block: latches, pin reads, external interrupts, port match, crossbar
`default_nettype none
//
// Function
// - Each external input triggers on chosen edge or level with chosen polarity.
// - External inputs watch their pins regardless of crossbar routing.
// - Edge-mode pending flag clears when the core vectors to its handler.
// - Level-mode pending flag follows the active level of the input.
// - Mismatch when masked pins differ from masked expected value on any port.
// - Mismatch event drives both an interrupt request and a wake-up.
// - Match comparison uses real pin levels whatever the routing.
// - Port writes go to a latch that drives the pins the crossbar does not route.
// - Plain port reads return pin levels, even for routed pins.
// - Read-modify-write accesses to ports read the latch instead.
// - Pins go to enabled peripherals in fixed priority order.
// - First crossbar register holds eight enables, all reset to zero.
// - UART transmit and receive sit on fixed pins four and five.
// - SPI takes three or four pins depending on its configuration.
// - Each placed signal after UART takes the lowest free, unskipped pin.
module pimc_top (
	input  wire logic                           clock,
	input  wire logic                           rst_b,
	input  wire pimc_pkg::pimc_sfr_req_t        sfr_req,
	output logic      [7:0]                     sfr_rdata,
	input  wire logic [1:0]                     irq_ack,
	output logic                                ext_irq_a,
	output logic                                ext_irq_b,
	output logic                                irq_port_match,
	output logic                                wake_port_match,
	input  wire pimc_pkg::pimc_periph_t         periph,
	output logic      [pimc_pkg::NFUNC-1:0]     periph_in,
	input  wire logic [pimc_pkg::NPIN-1:0]      pin_in,
	output logic      [pimc_pkg::NPIN-1:0]      pin_out,
	output logic      [pimc_pkg::NPIN-1:0]      pin_oe
);
	logic [pimc_pkg::NPORT-1:0][7:0]  port_latch;
	logic [pimc_pkg::NPORT-1:0][7:0]  port_expected_value;
	logic [pimc_pkg::NPORT-1:0][7:0]  port_compare_select;
	logic [pimc_pkg::NPORT-1:0][7:0]  port_skip_bits;
	logic [7:0]                       crossbar_enable_first;
	logic [7:0]                       ext_irq_config;
	logic                             spi_four_wire;
	logic [1:0]                       edge_sel;
	logic [1:0]                       pending;
	logic [1:0]                       prev_active;
	logic [pimc_pkg::NPIN-1:0]        pin_level;
	logic [pimc_pkg::NPORT-1:0][7:0]  pin_port;
	logic [1:0]                       active;
	logic [1:0]                       fire;
	logic [1:0][2:0]                  ext_sel;
	logic [1:0]                       ext_pol;
	logic                             wr_tctl;
	logic                             mismatch;
	logic [7:0]                       next_rdata;
	logic [pimc_pkg::NPIN-1:0]        pin_valid;
	logic [pimc_pkg::NPIN-1:0][3:0]   pin_func;
	logic [pimc_pkg::NFUNC-1:0]       func_valid;
	logic [pimc_pkg::NFUNC-1:0][4:0]  func_pin;
	logic [pimc_pkg::NPORT-1:0][7:0]  port_addr;
	logic [pimc_pkg::NPORT-1:0][7:0]  match_addr;
	logic [pimc_pkg::NPORT-1:0][7:0]  mask_addr;
	logic [pimc_pkg::NPORT-1:0][7:0]  skip_addr;

	assign port_addr = {pimc_pkg::ADDR_PORT2, pimc_pkg::ADDR_PORT1, pimc_pkg::ADDR_PORT0};
	assign match_addr = {pimc_pkg::ADDR_MATCH0 + 8'h02,
		pimc_pkg::ADDR_MATCH0 + 8'h01, pimc_pkg::ADDR_MATCH0};
	assign mask_addr = {pimc_pkg::ADDR_MASK0 + 8'h02,
		pimc_pkg::ADDR_MASK0 + 8'h01, pimc_pkg::ADDR_MASK0};
	assign skip_addr = {pimc_pkg::ADDR_SKIP0 + 8'h02,
		pimc_pkg::ADDR_SKIP0 + 8'h01, pimc_pkg::ADDR_SKIP0};

	// Pin synchroniser feeding interrupts, match and port reads
	pimc_sync #(
		.W(pimc_pkg::NPIN)
	) u_sync (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (pin_in),
		.stable   (pin_level)
	);

	assign pin_port = pin_level;

	// Crossbar placement
	pimc_xbar u_xbar (
		.crossbar_enables (crossbar_enable_first),
		.spi_four_wire    (spi_four_wire),
		.port_skip_bits   (port_skip_bits),
		.pin_valid        (pin_valid),
		.pin_func         (pin_func),
		.func_valid       (func_valid),
		.func_pin         (func_pin)
	);

	// Port output latches
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_latch <= {pimc_pkg::NPORT{pimc_pkg::PORT_RESET}};
		end else begin
			for (int n = 0; n < pimc_pkg::NPORT; n++) begin
				if (sfr_req.wr && sfr_req.addr == port_addr[n]) begin
					port_latch[n] <= sfr_req.wdata;
				end
			end
		end
	end

	// Match registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_expected_value <= '0;
		end else begin
			for (int n = 0; n < pimc_pkg::NPORT; n++) begin
				if (sfr_req.wr && sfr_req.addr == match_addr[n]) begin
					port_expected_value[n] <= sfr_req.wdata;
				end
			end
		end
	end

	// Mask registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_compare_select <= '0;
		end else begin
			for (int n = 0; n < pimc_pkg::NPORT; n++) begin
				if (sfr_req.wr && sfr_req.addr == mask_addr[n]) begin
					port_compare_select[n] <= sfr_req.wdata;
				end
			end
		end
	end

	// Skip registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			port_skip_bits <= '0;
		end else begin
			for (int n = 0; n < pimc_pkg::NPORT; n++) begin
				if (sfr_req.wr && sfr_req.addr == skip_addr[n]) begin
					port_skip_bits[n] <= sfr_req.wdata;
				end
			end
		end
	end

	// Crossbar enables
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			crossbar_enable_first <= pimc_pkg::ZERO_RESET;
		end else if (sfr_req.wr && sfr_req.addr == pimc_pkg::ADDR_XBAR0) begin
			crossbar_enable_first <= sfr_req.wdata;
		end
	end

	// External interrupt pin and polarity selection
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ext_irq_config <= pimc_pkg::ZERO_RESET;
		end else if (sfr_req.wr && sfr_req.addr == pimc_pkg::ADDR_EXT_CFG) begin
			ext_irq_config <= sfr_req.wdata;
		end
	end

	// SPI pin count selection
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			spi_four_wire <= 1'b0;
		end else if (sfr_req.wr && sfr_req.addr == pimc_pkg::ADDR_XBAR_CFG) begin
			spi_four_wire <= sfr_req.wdata[pimc_pkg::XCFG_SPI4];
		end
	end

	// External interrupt input selection and activity
	assign ext_sel[0] = ext_irq_config[pimc_pkg::CFG_SEL_A +: 3];
	assign ext_sel[1] = ext_irq_config[pimc_pkg::CFG_SEL_B +: 3];
	assign ext_pol[0] = ext_irq_config[pimc_pkg::CFG_POL_A];
	assign ext_pol[1] = ext_irq_config[pimc_pkg::CFG_POL_B];
	assign wr_tctl = sfr_req.wr && sfr_req.addr == pimc_pkg::ADDR_TIMER_CTL;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			active[c] = pin_port[0][ext_sel[c]] == ext_pol[c];
			fire[c] = active[c] & ~prev_active[c];
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			prev_active <= '0;
		end else begin
			prev_active <= active;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			edge_sel <= '0;
		end else if (wr_tctl) begin
			edge_sel[0] <= sfr_req.wdata[pimc_pkg::TCTL_EDGE_A];
			edge_sel[1] <= sfr_req.wdata[pimc_pkg::TCTL_EDGE_B];
		end
	end

	// Pending flags; a fresh edge wins over any clear in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pending <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (!edge_sel[c]) begin
					pending[c] <= active[c];
				end else if (fire[c]) begin
					pending[c] <= 1'b1;
				end else if (wr_tctl) begin
					pending[c] <= sfr_req.wdata[c == 0 ? pimc_pkg::TCTL_PEND_A
						: pimc_pkg::TCTL_PEND_B];
				end else if (irq_ack[c]) begin
					pending[c] <= 1'b0;
				end
			end
		end
	end

	assign ext_irq_a = pending[0];
	assign ext_irq_b = pending[1];

	// Port match comparison on synchronised pin levels
	always_comb begin
		mismatch = 1'b0;
		for (int n = 0; n < pimc_pkg::NPORT; n++) begin
			if ((pin_port[n] & port_compare_select[n])
				!= (port_expected_value[n] & port_compare_select[n])) begin
				mismatch = 1'b1;
			end
		end
	end

	// Mismatch interrupt request
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			irq_port_match <= 1'b0;
		end else begin
			irq_port_match <= mismatch;
		end
	end

	// Mismatch wake-up, kept apart so low-power logic can take it alone
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wake_port_match <= 1'b0;
		end else begin
			wake_port_match <= mismatch;
		end
	end

	// Register read path
	always_comb begin
		next_rdata = 8'h00;
		for (int n = 0; n < pimc_pkg::NPORT; n++) begin
			if (sfr_req.addr == port_addr[n]) begin
				next_rdata = sfr_req.rmw ? port_latch[n] : pin_port[n];
			end
			if (sfr_req.addr == match_addr[n]) begin
				next_rdata = port_expected_value[n];
			end
			if (sfr_req.addr == mask_addr[n]) begin
				next_rdata = port_compare_select[n];
			end
			if (sfr_req.addr == skip_addr[n]) begin
				next_rdata = port_skip_bits[n];
			end
		end
		case (sfr_req.addr)
			pimc_pkg::ADDR_XBAR0: begin
				next_rdata = crossbar_enable_first;
			end
			pimc_pkg::ADDR_EXT_CFG: begin
				next_rdata = ext_irq_config;
			end
			pimc_pkg::ADDR_XBAR_CFG: begin
				next_rdata = {7'h00, spi_four_wire};
			end
			pimc_pkg::ADDR_TIMER_CTL: begin
				next_rdata = {4'h0, pending[1], edge_sel[1], pending[0], edge_sel[0]};
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			sfr_rdata <= next_rdata;
		end
	end

	// Pin drivers: routed peripheral, else open-drain latch
	always_comb begin
		for (int p = 0; p < pimc_pkg::NPIN; p++) begin
			if (pin_valid[p]) begin
				pin_out[p] = periph.out[pin_func[p]];
				pin_oe[p] = periph.oe[pin_func[p]];
			end else begin
				pin_out[p] = 1'b0;
				pin_oe[p] = ~port_latch[p / 8][p % 8];
			end
		end
	end

	// Peripheral inputs taken from their assigned pins
	always_comb begin
		for (int f = 0; f < pimc_pkg::NFUNC; f++) begin
			periph_in[f] = func_valid[f] ? pin_in[func_pin[f]] : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### pimc_pkg.sv
// Package: constants, register map and carrier types for the port block
`default_nettype none
package pimc_pkg;
	localparam int NPORT = 3;
	localparam int NPIN = 24;
	localparam int XBAR_PINS = 20;
	localparam int NFUNC = 13;
	localparam int EXT_PINS = 8;

	localparam logic [7:0] ADDR_PORT0 = 8'h80;
	localparam logic [7:0] ADDR_PORT1 = 8'h90;
	localparam logic [7:0] ADDR_PORT2 = 8'ha0;
	localparam logic [7:0] ADDR_TIMER_CTL = 8'h88;
	localparam logic [7:0] ADDR_EXT_CFG = 8'he4;
	localparam logic [7:0] ADDR_XBAR0 = 8'he1;
	localparam logic [7:0] ADDR_XBAR_CFG = 8'he5;
	localparam logic [7:0] ADDR_MATCH0 = 8'hd8;
	localparam logic [7:0] ADDR_MASK0 = 8'hdb;
	localparam logic [7:0] ADDR_SKIP0 = 8'hd4;

	localparam logic [7:0] PORT_RESET = 8'hff;
	localparam logic [7:0] ZERO_RESET = 8'h00;
	localparam logic [NPIN-1:0] SYNC_RESET = 24'hffffff;

	localparam int TCTL_EDGE_A = 0;
	localparam int TCTL_PEND_A = 1;
	localparam int TCTL_EDGE_B = 2;
	localparam int TCTL_PEND_B = 3;
	localparam int CFG_SEL_A = 0;
	localparam int CFG_POL_A = 3;
	localparam int CFG_SEL_B = 4;
	localparam int CFG_POL_B = 7;
	localparam int XCFG_SPI4 = 0;

	localparam int XB_UART = 0;
	localparam int XB_SPI = 1;
	localparam int XB_TWOWIRE = 2;
	localparam int XB_CMP_A = 3;
	localparam int XB_CMP_A_ASYNC = 4;
	localparam int XB_CMP_B = 5;
	localparam int XB_CMP_B_ASYNC = 6;
	localparam int XB_SYSCLK = 7;

	localparam int FN_UART_TX = 0;
	localparam int FN_UART_RX = 1;
	localparam int FN_SPI_SCK = 2;
	localparam int FN_SPI_NSS = 5;
	localparam int FN_TW_SDA = 6;
	localparam int FN_CMP_A = 8;
	localparam int FN_SYSCLK = 12;
	localparam int UART_TX_PIN = 4;
	localparam int UART_RX_PIN = 5;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic       rmw;
		logic [7:0] wdata;
	} pimc_sfr_req_t;

	typedef struct packed {
		logic [NFUNC-1:0] out;
		logic [NFUNC-1:0] oe;
	} pimc_periph_t;
endpackage
`default_nettype wire

// ### pimc_sync.sv
// Three-flop pin synchroniser with agreement filter
`default_nettype none
module pimc_sync #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] stable
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s1 <= '1;
			s2 <= '1;
			s3 <= '1;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accept a bit only once the second and third stages agree
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stable <= '1;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2[i] == s3[i]) begin
					stable[i] <= s3[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### pimc_xbar.sv
// Priority crossbar placement of peripheral signals onto pins
`default_nettype none
module pimc_xbar (
	input  wire logic [7:0]                     crossbar_enables,
	input  wire logic                           spi_four_wire,
	input  wire logic [pimc_pkg::NPIN-1:0]      port_skip_bits,
	output logic      [pimc_pkg::NPIN-1:0]      pin_valid,
	output logic      [pimc_pkg::NPIN-1:0][3:0] pin_func,
	output logic      [pimc_pkg::NFUNC-1:0]     func_valid,
	output logic      [pimc_pkg::NFUNC-1:0][4:0] func_pin
);
	logic [pimc_pkg::NFUNC-1:0] want;
	logic [pimc_pkg::NPIN-1:0]  taken;
	logic                       found;

	always_comb begin
		want = '0;
		want[pimc_pkg::FN_SPI_SCK +: 3] = {3{crossbar_enables[pimc_pkg::XB_SPI]}};
		want[pimc_pkg::FN_SPI_NSS] = crossbar_enables[pimc_pkg::XB_SPI] & spi_four_wire;
		want[pimc_pkg::FN_TW_SDA +: 2] = {2{crossbar_enables[pimc_pkg::XB_TWOWIRE]}};
		want[pimc_pkg::FN_CMP_A] = crossbar_enables[pimc_pkg::XB_CMP_A];
		want[pimc_pkg::FN_CMP_A + 1] = crossbar_enables[pimc_pkg::XB_CMP_A_ASYNC];
		want[pimc_pkg::FN_CMP_A + 2] = crossbar_enables[pimc_pkg::XB_CMP_B];
		want[pimc_pkg::FN_CMP_A + 3] = crossbar_enables[pimc_pkg::XB_CMP_B_ASYNC];
		want[pimc_pkg::FN_SYSCLK] = crossbar_enables[pimc_pkg::XB_SYSCLK];
	end

	always_comb begin
		taken = '0;
		pin_valid = '0;
		pin_func = '0;
		func_valid = '0;
		func_pin = '0;
		found = 1'b0;
		// UART sits on fixed pins ahead of everything else
		if (crossbar_enables[pimc_pkg::XB_UART]) begin
			taken[pimc_pkg::UART_TX_PIN] = 1'b1;
			taken[pimc_pkg::UART_RX_PIN] = 1'b1;
			pin_valid[pimc_pkg::UART_TX_PIN] = 1'b1;
			pin_valid[pimc_pkg::UART_RX_PIN] = 1'b1;
			pin_func[pimc_pkg::UART_TX_PIN] = 4'(pimc_pkg::FN_UART_TX);
			pin_func[pimc_pkg::UART_RX_PIN] = 4'(pimc_pkg::FN_UART_RX);
			func_valid[pimc_pkg::FN_UART_TX] = 1'b1;
			func_valid[pimc_pkg::FN_UART_RX] = 1'b1;
			func_pin[pimc_pkg::FN_UART_TX] = 5'(pimc_pkg::UART_TX_PIN);
			func_pin[pimc_pkg::FN_UART_RX] = 5'(pimc_pkg::UART_RX_PIN);
		end
		// Remaining signals in priority order take the lowest free pin
		for (int f = pimc_pkg::FN_SPI_SCK; f < pimc_pkg::NFUNC; f++) begin
			found = 1'b0;
			for (int p = 0; p < pimc_pkg::XBAR_PINS; p++) begin
				if (want[f] && !found && !taken[p] && !port_skip_bits[p]) begin
					found = 1'b1;
					taken[p] = 1'b1;
					pin_valid[p] = 1'b1;
					pin_func[p] = 4'(f);
					func_valid[f] = 1'b1;
					func_pin[f] = 5'(p);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### pimc_monitor.sv
// Checker for the port block, bound to its top module
`default_nettype none
module pimc_monitor (
	input wire logic                          clock,
	input wire logic                          rst_b,
	input wire pimc_pkg::pimc_sfr_req_t       sfr_req,
	input wire logic [7:0]                    sfr_rdata,
	input wire logic [1:0]                    irq_ack,
	input wire logic                          ext_irq_a,
	input wire logic                          irq_port_match,
	input wire logic                          wake_port_match,
	input wire pimc_pkg::pimc_periph_t        periph,
	input wire logic [pimc_pkg::NFUNC-1:0]    periph_in,
	input wire logic [pimc_pkg::NPIN-1:0]     pin_in,
	input wire logic [pimc_pkg::NPIN-1:0]     pin_out,
	input wire logic [pimc_pkg::NPIN-1:0]     pin_oe
);
	logic [23:0] lat;
	logic [7:0]  xb;
	logic [7:0]  sk;
	logic [7:0]  cfg;
	logic [7:0]  tc;
	logic [3:0]  qc;
	logic        cfg_wr;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	assign cfg_wr = sfr_req.wr && (sfr_req.addr == pimc_pkg::ADDR_EXT_CFG ||
		sfr_req.addr == pimc_pkg::ADDR_TIMER_CTL);

	// Mirrors of the registers written over the bus
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			lat <= 24'hffffff;
			xb  <= 8'h00;
			sk  <= 8'h00;
			cfg <= 8'h00;
			tc  <= 8'h00;
		end else if (sfr_req.wr) begin
			case (sfr_req.addr)
				pimc_pkg::ADDR_PORT0: lat[7:0] <= sfr_req.wdata;
				pimc_pkg::ADDR_PORT1: lat[15:8] <= sfr_req.wdata;
				pimc_pkg::ADDR_PORT2: lat[23:16] <= sfr_req.wdata;
				pimc_pkg::ADDR_XBAR0: xb <= sfr_req.wdata;
				pimc_pkg::ADDR_SKIP0: sk <= sfr_req.wdata;
				pimc_pkg::ADDR_EXT_CFG: cfg <= sfr_req.wdata;
				pimc_pkg::ADDR_TIMER_CTL: tc <= sfr_req.wdata;
				default: ;
			endcase
		end
	end

	// Cycles since port 0 pins or interrupt setup last changed
	always_ff @(posedge clock) begin
		if (!rst_b || $changed(pin_in[7:0]) || cfg_wr) begin
			qc <= 4'h0;
		end else if (qc != 4'hf) begin
			qc <= qc + 4'h1;
		end
	end

	chk_match_twin: assert property (irq_port_match == wake_port_match)
		else $error("match irq and wake differ");
	chk_gpio_drive: assert property (xb == 8'h00 |-> pin_oe == ~lat && pin_out == 24'h0)
		else $error("gpio pin drive not from latch");
	chk_latch_read: assert property (sfr_req.rd && sfr_req.rmw &&
		sfr_req.addr == pimc_pkg::ADDR_PORT0 |=> sfr_rdata == $past(lat[7:0]))
		else $error("rmw read not latch");
	chk_xbar_read: assert property (sfr_req.rd && sfr_req.addr == pimc_pkg::ADDR_XBAR0
		|=> sfr_rdata == $past(xb))
		else $error("crossbar readback wrong");
	chk_uart_tx: assert property (xb[0] |-> pin_out[4] == periph.out[0] &&
		pin_oe[4] == periph.oe[0])
		else $error("uart tx not on pin 4");
	chk_uart_rx: assert property (xb[0] |-> periph_in[1] == pin_in[5])
		else $error("uart rx not from pin 5");
	chk_spi_first: assert property (xb[1] && !sk[0] |-> pin_out[0] == periph.out[2])
		else $error("spi clock not on lowest pin");
	chk_level_follow: assert property (!tc[0] && qc >= 4'h8
		|-> ext_irq_a == (pin_in[cfg[2:0]] == cfg[3]))
		else $error("level pending wrong");
	chk_ack_clear: assert property (tc[0] && irq_ack[0] && qc >= 4'h8 && !sfr_req.wr
		|=> !ext_irq_a)
		else $error("edge pending not cleared by ack");
endmodule

bind pimc_top pimc_monitor u_mon (
	.clock(clock),
	.rst_b(rst_b),
	.sfr_req(sfr_req),
	.sfr_rdata(sfr_rdata),
	.irq_ack(irq_ack),
	.ext_irq_a(ext_irq_a),
	.irq_port_match(irq_port_match),
	.wake_port_match(wake_port_match),
	.periph(periph),
	.periph_in(periph_in),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe(pin_oe)
);
`default_nettype wire

// ### pimc_pin_model.sv
// Off-chip pin sources with the block's open-drain drive resolved on each pin
`default_nettype none
module pimc_pin_model (
	input  wire logic [pimc_pkg::NPIN-1:0] pin_out,
	input  wire logic [pimc_pkg::NPIN-1:0] pin_oe,
	input  wire logic [pimc_pkg::NPIN-1:0] src,
	output logic      [pimc_pkg::NPIN-1:0] pin_in
);
	always_comb begin
		for (int i = 0; i < pimc_pkg::NPIN; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : src[i];
		end
	end
endmodule
`default_nettype wire

// ### tb_top.sv
// Testbench: port access, external inputs, port match and crossbar placement
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clock = 1'b0;
	logic                    rst_b = 1'b0;
	pimc_pkg::pimc_sfr_req_t req = '0;
	pimc_pkg::pimc_periph_t  per = '0;
	logic [1:0]              ack = 2'b00;
	logic [23:0]             src = 24'hfffffb;
	logic [23:0]             pin_in;
	logic [23:0]             pin_out;
	logic [23:0]             pin_oe;
	logic [12:0]             periph_in;
	logic [7:0]              sfr_rdata;
	logic                    ext_irq_a;
	logic                    ext_irq_b;
	logic                    irq_port_match;
	logic                    wake_port_match;
	int                      error_cnt = 0;
	int                      compares = 0;
	int                      cyc = 0;

	always #2.5 clock = ~clock;

	pimc_top DUT (.clock(clock), .rst_b(rst_b), .sfr_req(req), .sfr_rdata(sfr_rdata),
		.irq_ack(ack), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
		.irq_port_match(irq_port_match), .wake_port_match(wake_port_match),
		.periph(per), .periph_in(periph_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe));
	pimc_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .src(src), .pin_in(pin_in));

	task automatic finish_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc++;
		if (cyc == 4000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, rmw: 1'b0, wdata: d};
		@(negedge clock);
		req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] d);
		@(negedge clock);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, rmw: m, wdata: 8'h00};
		@(negedge clock);
		req = '0;
		d = sfr_rdata;
	endtask

	task automatic wt(input int s, input logic v, input string nm);
		logic g;
		for (int i = 0; i < 12; i++) begin
			@(negedge clock);
			g = (s == 0) ? ext_irq_a : (s == 1) ? ext_irq_b : irq_port_match;
			if (g === v) break;
		end
		chk(nm, {23'h0, v}, {23'h0, g});
	endtask

	task automatic t_reset();
		logic [7:0] d;
		rd(pimc_pkg::ADDR_XBAR0, 1'b0, d);
		chk("xbar0 reset", 24'h0, {16'h0, d});
		rd(8'h00, 1'b0, d);
		chk("unmapped read", 24'h0, {16'h0, d});
		chk("pin_oe reset", 24'h0, pin_oe);
	endtask

	task automatic t_latch();
		logic [7:0] d;
		wr(pimc_pkg::ADDR_PORT0, 8'h0f);
		chk("pin_oe latch", 24'h0000f0, pin_oe);
		repeat (6) @(negedge clock);
		rd(pimc_pkg::ADDR_PORT0, 1'b0, d);
		chk("port0 pins", 24'h00000b, {16'h0, d});
		rd(pimc_pkg::ADDR_PORT0, 1'b1, d);
		chk("port0 latch", 24'h00000f, {16'h0, d});
		wr(pimc_pkg::ADDR_PORT0, 8'hff);
	endtask

	task automatic edge_case(input logic p);
		src[1] = ~p;
		wr(pimc_pkg::ADDR_EXT_CFG, {4'ha, p, 3'h1});
		wr(pimc_pkg::ADDR_TIMER_CTL, 8'h01);
		repeat (8) @(negedge clock);
		wt(0, 1'b0, "ext a idle");
		src[1] = p;
		wt(0, 1'b1, "ext a edge");
		repeat (8) @(negedge clock);
		ack = 2'b01;
		@(negedge clock);
		ack = 2'b00;
		chk("ext a after ack", 24'h0, {23'h0, ext_irq_a});
	endtask

	task automatic level_case(input logic p);
		src[2] = ~p;
		wr(pimc_pkg::ADDR_EXT_CFG, {p, 3'h2, 4'h9});
		wt(1, 1'b0, "ext b inactive");
		src[2] = p;
		wt(1, 1'b1, "ext b active");
		repeat (4) @(negedge clock);
		chk("ext b held", 24'h1, {23'h0, ext_irq_b});
		src[2] = ~p;
		wt(1, 1'b0, "ext b released");
	endtask

	task automatic t_match();
		src[3] = 1'b0;
		wr(pimc_pkg::ADDR_MATCH0, 8'h09);
		wr(pimc_pkg::ADDR_MASK0, 8'h01);
		wt(2, 1'b0, "match idle");
		src[0] = 1'b0;
		wt(2, 1'b1, "mismatch");
		chk("wake", 24'h1, {23'h0, wake_port_match});
		src[0] = 1'b1;
		wt(2, 1'b0, "match again");
	endtask

	task automatic t_xbar();
		int fn_t[7] = '{0, 2, 3, 4, 5, 6, 7};
		int pn_t[7] = '{4, 0, 1, 2, 6, 7, 8};
		logic [7:0] d;
		wr(pimc_pkg::ADDR_SKIP0, 8'h08);
		wr(pimc_pkg::ADDR_XBAR_CFG, 8'h01);
		wr(pimc_pkg::ADDR_XBAR0, 8'h07);
		per.oe = '1;
		for (int i = 0; i < 7; i++) begin
			@(negedge clock);
			per.out = 13'h1 << fn_t[i];
			#1;
			chk("pin_out placed", 24'h1 << pn_t[i], pin_out);
			chk("periph_in placed", {11'h0, 13'h1f00 | (13'h1 << fn_t[i])},
				{11'h0, periph_in});
		end
		rd(pimc_pkg::ADDR_XBAR0, 1'b0, d);
		chk("xbar0 readback", 24'h000007, {16'h0, d});
		wr(pimc_pkg::ADDR_XBAR_CFG, 8'h00);
		per.out = 13'h1 << pimc_pkg::FN_TW_SDA;
		#1;
		chk("sda on three-wire", 24'h000040, pin_out);
		wt(2, 1'b1, "match on routed pin");
		chk("ext a before", 24'h0, {23'h0, ext_irq_a});
		per.out = 13'h1 << 3;
		wt(0, 1'b1, "ext a on routed pin");
		per = '0;
	endtask

	initial begin
		repeat (16) @(negedge clock);
		rst_b = 1'b1;
		t_reset();
		t_latch();
		edge_case(1'b0);
		edge_case(1'b1);
		level_case(1'b1);
		level_case(1'b0);
		t_match();
		t_xbar();
		finish_test();
	end
endmodule
`default_nettype wire
